// File: isl_pkg.sv
package isl_pkg;
  // Register indices (printed offsets are not all multiples of four)
  localparam logic [7:0] REG_BUF = 8'h13;
  localparam logic [7:0] REG_CTRL = 8'h14;
  localparam logic [7:0] REG_OWN = 8'h93;
  localparam logic [7:0] REG_STAT = 8'h94;
  localparam logic [7:0] REG_AUX = 8'h20;
  localparam int ADDR_W = 10;
  // Reset values
  localparam logic [7:0] MASK_RST = 8'hFF;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] OWN_RST = 8'h00;
  // Control field positions
  localparam int CTRL_WRITE_COLLISION = 7;
  localparam int CTRL_OV = 6;
  localparam int CTRL_EN = 5;
  localparam int CTRL_REL = 4;
  // Status field positions
  localparam int ST_DA = 5;
  localparam int ST_P = 4;
  localparam int ST_S = 3;
  localparam int ST_RW = 2;
  localparam int ST_UA = 1;
  localparam int ST_BF = 0;
  // Aux register fields
  localparam int AUX_IF = 0;
  localparam int AUX_IE = 1;
  localparam int AUX_SCLD = 2;
  localparam int AUX_SDAD = 3;
  // Mode codes and bit counts
  localparam logic [3:0] MODE_S7 = 4'h6;
  localparam logic [3:0] MODE_S10 = 4'h7;
  localparam logic [3:0] MODE_MSK = 4'h9;
  localparam logic [3:0] MODE_FWM = 4'hB;
  localparam logic [3:0] MODE_S7SP = 4'hE;
  localparam logic [3:0] MODE_S10SP = 4'hF;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h9;
  // Slave states, Gray coded
  typedef enum logic [2:0] {
    ISL_IDLE = 3'b000,
    ISL_ADDR = 3'b001,
    ISL_ACK = 3'b011,
    ISL_TX = 3'b010,
    ISL_MACK = 3'b110,
    ISL_RX = 3'b111
  } isl_state_e;
endpackage

// File: isl_sync.sv
`timescale 1ns/1ns
`default_nettype none
module isl_sync
  import isl_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // Pin and result
  input wire logic pin,
  output logic level
);
  logic stage1;
  // Two flops, first one read only by second
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b1;
      level <= 1'b1;
    end else if (clk_en) begin
      stage1 <= pin;
      level <= stage1;
    end
  end
endmodule // isl_sync
`default_nettype wire

// File: isl_top.sv
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module isl_top
  import isl_pkg::*;
(
  // System
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Interrupt request to the core
  output logic port_irq
);
  logic scl;
  logic sda;
  logic scl_d;
  logic sda_d;
  logic [7:0] port_control;
  logic [7:0] port_status;
  logic [7:0] address_mask;
  logic [7:0] own_address_register;
  logic [7:0] transfer_buffer;
  logic [7:0] shift_register;
  logic [7:0] mask_snap;
  logic [3:0] bit_cnt;
  logic port_interrupt_flag;
  logic port_interrupt_enable;
  logic [1:0] pin_direction;
  logic clock_hold;
  logic sda_drive;
  logic ack_done;
  isl_state_e state;

  // Pin synchronisers
  isl_sync u_scl (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .pin(scl_in), .level(scl));
  isl_sync u_sda (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .pin(sda_in), .level(sda));

  // Line events
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_cond = scl & scl_d & sda_d & ~sda;
  wire stop_cond = scl & scl_d & ~sda_d & sda;
  wire [3:0] mode_select = port_control[3:0];
  wire port_enable = port_control[CTRL_EN];
  wire clock_release = port_control[CTRL_REL];
  wire ten_bit = (mode_select == MODE_S10) || (mode_select == MODE_S10SP);
  wire slave_on = port_enable && ((mode_select == MODE_S7) || ten_bit ||
                  (mode_select == MODE_S7SP));
  wire sp_mode = (mode_select == MODE_FWM) || (mode_select == MODE_S7SP) ||
                 (mode_select == MODE_S10SP);
  // Address compare with mask; bit 0 only in mode 0111
  wire [7:0] eff_mask = {mask_snap[7:1], mask_snap[0] & (mode_select == MODE_S10)};
  wire [7:0] diff = (shift_register ^ own_address_register) & eff_mask;
  wire addr_match = (diff[7:1] == 7'h00) && (!ten_bit || !diff[0]);
  wire overflow = port_status[ST_BF] | port_control[CTRL_OV];

  // Register decode; mask mode redirects own-address slot
  wire acc = avs_read | avs_write;
  wire sel_buf = avs_address == {2'b00, REG_BUF};
  wire sel_ctrl = avs_address == {2'b00, REG_CTRL};
  wire sel_own = avs_address == {2'b00, REG_OWN};
  wire sel_stat = avs_address == {2'b00, REG_STAT};
  wire sel_aux = avs_address == {2'b00, REG_AUX};
  wire redirect = mode_select == MODE_MSK;
  wire wr_go = avs_write & ~avs_waitrequest & clk_en;
  wire rd_go = avs_read & ~avs_waitrequest & clk_en;
  wire rd_load = avs_read & avs_waitrequest; // Wait cycle loads read data
  wire wr_buf = wr_go & sel_buf;
  wire rd_buf = rd_go & sel_buf;
  wire [7:0] wdat = avs_writedata[7:0];
  wire [7:0] aux_rd = {4'h0, pin_direction, port_interrupt_enable, port_interrupt_flag};
  wire [7:0] rd_mux = sel_buf ? transfer_buffer :
                      sel_ctrl ? port_control :
                      (sel_own && redirect) ? address_mask :
                      sel_own ? own_address_register :
                      sel_stat ? port_status :
                      sel_aux ? aux_rd : 8'h00;

  // Bus slave: one wait cycle, then answer
  // Read data loaded in the wait cycle, stands while waitrequest is low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en) begin
      avs_waitrequest <= ~(acc & avs_waitrequest);
      if (rd_load) avs_readdata <= {24'h000000, rd_mux};
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      address_mask <= MASK_RST;
      own_address_register <= OWN_RST;
      port_interrupt_enable <= 1'b0;
      pin_direction <= 2'b11;
    end else if (wr_go) begin
      if (sel_own && redirect) address_mask <= wdat;
      if (sel_own && !redirect) own_address_register <= wdat;
      if (sel_aux) port_interrupt_enable <= wdat[AUX_IE];
      if (sel_aux) pin_direction <= wdat[AUX_SDAD:AUX_SCLD];
    end
  end

  // Main slave engine, status and flags
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ISL_IDLE;
      port_control <= CTRL_RST;
      port_status <= 8'h00;
      transfer_buffer <= 8'h00;
      shift_register <= 8'h00;
      mask_snap <= MASK_RST;
      bit_cnt <= 4'h0;
      port_interrupt_flag <= 1'b0;
      clock_hold <= 1'b0;
      sda_drive <= 1'b0;
      ack_done <= 1'b0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (clk_en) begin
      scl_d <= scl;
      sda_d <= sda;
      // Software writes first; hardware events below win
      if (wr_go && sel_ctrl) port_control <= wdat;
      if (wr_go && sel_aux && wdat[AUX_IF]) port_interrupt_flag <= 1'b0;
      if (rd_buf) port_status[ST_BF] <= 1'b0;
      if (wr_buf) begin
        transfer_buffer <= wdat;
        shift_register <= wdat;
        if (state == ISL_TX && bit_cnt != 4'h0) port_control[CTRL_WRITE_COLLISION] <= 1'b1;
      end
      if (!port_enable) begin
        port_status[ST_S] <= 1'b0;
        port_status[ST_P] <= 1'b0;
        state <= ISL_IDLE;
        clock_hold <= 1'b0;
        sda_drive <= 1'b0;
      end else if (start_cond) begin
        port_status[ST_S] <= 1'b1;
        port_status[ST_P] <= 1'b0;
        if (sp_mode) port_interrupt_flag <= 1'b1;
        state <= slave_on ? ISL_ADDR : ISL_IDLE;
        mask_snap <= address_mask;
        bit_cnt <= 4'h0;
        sda_drive <= 1'b0;
      end else if (stop_cond) begin
        port_status[ST_P] <= 1'b1;
        port_status[ST_S] <= 1'b0;
        if (sp_mode || port_interrupt_enable) port_interrupt_flag <= 1'b1;
        state <= ISL_IDLE;
        sda_drive <= 1'b0;
      end else begin
        case (state)
          ISL_IDLE: begin
            bit_cnt <= 4'h0;
          end
          ISL_ADDR: begin
            if (scl_rise) begin
              shift_register <= {shift_register[6:0], sda};
              bit_cnt <= bit_cnt + 4'h1;
            end
            if (scl_fall && bit_cnt == BIT_LAST) begin
              if (addr_match && !overflow) begin
                transfer_buffer <= shift_register;
                port_status[ST_BF] <= 1'b1;
                port_status[ST_RW] <= shift_register[0];
                port_status[ST_DA] <= 1'b0;
                sda_drive <= 1'b1;
                state <= ISL_ACK;
              end else begin
                state <= ISL_IDLE;
              end
              bit_cnt <= 4'h0;
            end
          end
          ISL_ACK: begin
            if (scl_fall) begin
              port_interrupt_flag <= 1'b1;
              sda_drive <= 1'b0;
              bit_cnt <= 4'h0;
              if (port_status[ST_RW]) begin
                port_control[CTRL_REL] <= 1'b0;
                state <= ISL_TX;
              end else begin
                state <= ISL_RX;
              end
            end
          end
          ISL_TX: begin
            // Data changes on falling edges, first bit once released with SCL low; stable while SCL high
            if (bit_cnt == 4'h0 && clock_release && !scl) begin
              sda_drive <= ~shift_register[7];
              shift_register <= {shift_register[6:0], 1'b0};
              bit_cnt <= 4'h1;
            end else if (scl_fall && bit_cnt != 4'h0) begin
              if (bit_cnt == BIT_LAST) begin
                sda_drive <= 1'b0;
                state <= ISL_MACK;
              end else begin
                sda_drive <= ~shift_register[7];
                shift_register <= {shift_register[6:0], 1'b0};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          ISL_MACK: begin
            if (scl_rise) ack_done <= sda;
            if (scl_fall) begin
              port_interrupt_flag <= 1'b1;
              bit_cnt <= 4'h0;
              if (ack_done) begin
                port_status <= 8'h00;
                state <= ISL_IDLE;
              end else begin
                port_control[CTRL_REL] <= 1'b0;
                port_status[ST_DA] <= 1'b1;
                state <= ISL_TX;
              end
            end
          end
          ISL_RX: begin
            // Reception belongs to neighbouring logic; idle here
            state <= ISL_IDLE;
          end
          default: state <= ISL_IDLE;
        endcase
      end
      // Hold SCL only after it is seen low
      if (!clock_release && !scl && port_enable) clock_hold <= 1'b1;
      else if (clock_release) clock_hold <= 1'b0;
    end
  end

  // Pin drivers; master mode pulls low by direction bits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      port_irq <= 1'b0;
    end else if (clk_en) begin
      scl_oe <= clock_hold | (port_enable & ~pin_direction[0]);
      sda_oe <= sda_drive | (port_enable & ~pin_direction[1]);
      port_irq <= port_interrupt_flag & port_interrupt_enable;
    end
  end

  // Assertions
  property p_mask_reset;
    @(posedge clk_sys) $rose(rst_n) |-> address_mask == MASK_RST;
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("mask not ones after reset");

  property p_redirect;
    @(posedge clk_sys) disable iff (!rst_n)
      (wr_go && sel_own && redirect) |=> (address_mask == $past(wdat)) && $stable(own_address_register);
  endproperty
  a_redirect: assert property (p_redirect) else $error("mask redirect failed");

  property p_irq_ack;
    @(posedge clk_sys) disable iff (!rst_n)
      (clk_en && port_enable && !start_cond && !stop_cond && state == ISL_ACK && scl_fall)
      |=> port_interrupt_flag;
  endproperty
  a_irq_ack: assert property (p_irq_ack) else $error("flag not set on ninth fall");

  property p_sp_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      (clk_en && !port_enable) |=> !port_status[ST_S] && !port_status[ST_P];
  endproperty
  a_sp_clear: assert property (p_sp_clear) else $error("start stop not cleared");

  sequence s_stop_seen;
    clk_en && port_enable && stop_cond;
  endsequence
  property p_stop_free;
    @(posedge clk_sys) disable iff (!rst_n) s_stop_seen |=> port_status[ST_P];
  endproperty
  a_stop_free: assert property (p_stop_free) else $error("stop not recorded");

  property p_hold_needs_low;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(clock_hold) |-> !$past(scl);
  endproperty
  a_hold_needs_low: assert property (p_hold_needs_low) else $error("hold without low");

  property p_nack_reset;
    @(posedge clk_sys) disable iff (!rst_n)
      (clk_en && port_enable && !start_cond && !stop_cond && state == ISL_MACK && scl_fall && ack_done)
      |=> state == ISL_IDLE ##0 port_status == 8'h00;
  endproperty
  a_nack_reset: assert property (p_nack_reset) else $error("nack did not reset");

  property p_rw_set;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(state == ISL_ACK) |-> port_status[ST_RW] == transfer_buffer[0] ##1 sda_oe;
  endproperty
  a_rw_set: assert property (p_rw_set) else $error("read match status wrong");
endmodule // isl_top
`default_nettype wire

// File: isl_mst.sv
`timescale 1ns/1ns
`default_nettype none
module isl_mst (
  // Wired bus lines
  input wire logic scl_line,
  input wire logic sda_line,
  // Open-drain pulls, high pulls low
  output logic scl_low,
  output logic sda_low,
  // Faults seen on the wire
  output logic [7:0] n_viol
);
  localparam int H = 200;
  // Lines released at power-up
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    n_viol = 8'h00;
  end
  // Release SCL, wait out any stretching, bounded
  task automatic scl_up();
    int n;
    scl_low = 1'b0;
    for (n = 0; n < 400 && scl_line !== 1'b1; n++) #25;
    if (n == 400) n_viol = n_viol + 8'h01;
  endtask
  // One bit: data set in low phase, sampled mid-high, checked stable
  task automatic bit_cyc(input logic o, output logic s);
    sda_low = !o;
    #(H);
    scl_up();
    #(H/2);
    s = sda_line;
    #(H/2);
    if (sda_line !== s) n_viol = n_viol + 8'h01;
    scl_low = 1'b1;
  endtask
  // Start condition, phase offset from the system clock
  task automatic start();
    #13;
    sda_low = 1'b0;
    scl_up();
    #(H);
    sda_low = 1'b1;
    #(H);
    scl_low = 1'b1;
  endtask
  // Stop condition
  task automatic stop();
    sda_low = 1'b1;
    #(H);
    scl_up();
    #(H);
    sda_low = 1'b0;
    #(H);
  endtask
  // Address or data byte out, ninth bit returned
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(b[i], s);
    bit_cyc(1'b1, ack);
  endtask
  // Byte in; nack high releases SDA on the ninth bit
  task automatic rd_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(1'b1, b[i]);
    bit_cyc(nack, s);
  endtask
endmodule // isl_mst
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import isl_pkg::*;
  logic clk_sys, rst_n, clk_en, avs_read, avs_write;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic avs_waitrequest, scl_out, scl_oe, sda_out, sda_oe, port_irq, m_scl_low, m_sda_low;
  logic [7:0] n_viol, rd;
  logic [23:0] rd_hi;
  logic ack;
  wire scl_line;
  wire sda_line;
  int n_errors, num_checks;
  // Open drain with pull-ups
  assign scl_line = !(scl_oe | m_scl_low);
  assign sda_line = !(sda_oe | m_sda_low);
  isl_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl_line),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .port_irq(port_irq));
  isl_mst i_mst (.scl_line(scl_line), .sda_line(sda_line), .scl_low(m_scl_low),
    .sda_low(m_sda_low), .n_viol(n_viol));
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One bus cycle, held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    int n;
    @(posedge clk_sys);
    avs_address <= {2'b00, a};
    avs_writedata <= {24'h0, wd};
    avs_read <= !wr;
    avs_write <= wr;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 50) begin
      n_errors++;
      report_and_stop();
    end
    rd = avs_readdata[7:0];
    rd_hi = avs_readdata[31:8];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  // Masked read and compare
  task automatic rdm(input string nm, input logic [7:0] a, input logic [7:0] m,
      input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(nm, rd & m, exp);
    chk("rd upper", {7'h0, |rd_hi}, 8'h00);
  endtask
  // Let the line synchronisers catch up
  task automatic settle();
    repeat (6) @(posedge clk_sys);
  endtask
  // Hang guard
  initial begin
    #2000000;
    n_errors++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdm("ctrl", REG_CTRL, 8'hFF, CTRL_RST);
    rdm("stat", REG_STAT, 8'hFF, 8'h00);
    rdm("unmapped", 8'hFF, 8'hFF, 8'h00);
    wr(8'hFF, 8'h5A);
    wr(REG_CTRL, {4'h0, MODE_MSK});
    rdm("mask", REG_OWN, 8'hFF, MASK_RST);
    wr(REG_OWN, 8'hF0);
    rdm("mask", REG_OWN, 8'hFF, 8'hF0);
    wr(REG_CTRL, {4'h0, MODE_S7});
    rdm("own", REG_OWN, 8'hFF, OWN_RST);
    wr(REG_OWN, 8'h50);
    rdm("own", REG_OWN, 8'hFF, 8'h50);
    wr(REG_CTRL, {4'h3, MODE_S7});
    $display("test registers done");
    // Masked read match, two bytes sent, master ends with no acknowledge
    i_mst.start();
    i_mst.wr_byte(8'h5B, ack);
    chk("addr ack", {7'h0, ack}, 8'h00);
    settle();
    chk("scl held", {7'h0, scl_oe}, 8'h01);
    rdm("release", REG_CTRL, 8'h10, 8'h00);
    rdm("rw", REG_STAT, 8'h04, 8'h04);
    rdm("start", REG_STAT, 8'h18, 8'h08);
    rdm("flag", REG_AUX, 8'h01, 8'h01);
    rdm("buffer", REG_BUF, 8'hFF, 8'h5B);
    wr(REG_AUX, 8'h0D);
    rdm("flag", REG_AUX, 8'h01, 8'h00);
    wr(REG_BUF, 8'hA5);
    wr(REG_CTRL, {4'h3, MODE_S7});
    settle();
    chk("scl free", {7'h0, scl_oe}, 8'h00);
    i_mst.rd_byte(1'b0, rd);
    chk("tx data", rd, 8'hA5);
    settle();
    chk("scl held", {7'h0, scl_oe}, 8'h01);
    rdm("release", REG_CTRL, 8'h10, 8'h00);
    rdm("data flag", REG_STAT, 8'h20, 8'h20);
    rdm("flag", REG_AUX, 8'h01, 8'h01);
    wr(REG_AUX, 8'h0D);
    wr(REG_BUF, 8'h3C);
    wr(REG_CTRL, {4'h3, MODE_S7});
    settle();
    i_mst.rd_byte(1'b1, rd);
    chk("tx data", rd, 8'h3C);
    settle();
    rdm("flag", REG_AUX, 8'h01, 8'h01);
    rdm("rw", REG_STAT, 8'h04, 8'h00);
    i_mst.stop();
    settle();
    rdm("stop", REG_STAT, 8'h18, 8'h10);
    $display("test transmit done");
    // Full mask, same address now refused
    wr(REG_CTRL, {4'h0, MODE_MSK});
    rdm("disabled", REG_STAT, 8'h18, 8'h00);
    wr(REG_OWN, 8'hFF);
    wr(REG_CTRL, {4'h3, MODE_S7});
    i_mst.start();
    i_mst.wr_byte(8'h5B, ack);
    chk("addr nack", {7'h0, ack}, 8'h01);
    i_mst.stop();
    $display("test mask done");
    // Start/stop interrupts with the slave idle
    wr(REG_CTRL, {4'h3, MODE_FWM});
    wr(REG_AUX, 8'h0F);
    i_mst.start();
    settle();
    rdm("flag", REG_AUX, 8'h01, 8'h01);
    wr(REG_AUX, 8'h0F);
    i_mst.wr_byte(8'hA0, ack);
    chk("idle nack", {7'h0, ack}, 8'h01);
    wr(REG_AUX, 8'h0F);
    i_mst.stop();
    settle();
    rdm("flag", REG_AUX, 8'h01, 8'h01);
    chk("irq", {7'h0, port_irq}, 8'h01);
    wr(REG_AUX, 8'h09);
    settle();
    chk("oe", {6'h0, scl_oe, sda_oe}, 8'h02);
    chk("out level", {6'h0, scl_out, sda_out}, 8'h00);
    chk("sda level", {7'h0, sda_line}, 8'h01);
    wr(REG_AUX, 8'h05);
    settle();
    chk("oe", {6'h0, scl_oe, sda_oe}, 8'h01);
    wr(REG_AUX, 8'h0C);
    settle();
    chk("oe", {6'h0, scl_oe, sda_oe}, 8'h00);
    chk("irq", {7'h0, port_irq}, 8'h00);
    $display("test master done");
    chk("wire faults", n_viol, 8'h00);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
